// *** hdl/dds_host_port.sv ***
/*
  Host programming port: serial link on its own clock, parallel bus, commit strobe.
  Assumes the serial clock period is at least eight clk_sys periods and parallel
  strobes last at least three clk_sys periods; clk_sys stands in as the sync clock.
*/
`timescale 1ns/1ps
// Summary of operation
// - Instruction bit 7 high reads, low writes
// - Instruction bit 6 is ignored
// - Low six bits address the whole cycle
// - Chip select high floats both data pins
// - Chip select high suspends, progress kept
// - Control bit 1 chooses input-only data pin
// - Separate output driven only in 3-wire mode
// - Abort resets port, registers untouched
// - After abort next byte is instruction
// - Commit edge copies buffer into active
// - Serial clock may run through phases
// - Control bit 0 selects LSB-first order
// - LSB-first covers instruction byte too
// - Highest numbered register bit is MSB
// - All select pins low selects parallel
// - Width pin picks 8 or 16 bits
// - Upper byte addressed, lower byte one below
// - Separate strobes write any byte once
// - Parallel read returns register contents
// - Select code 0001 selects serial
// - Write bits sampled on rising clock
// - Reads from active, driven on falling edge
// - Whole bytes kept, partial bytes dropped
module dds_host_port (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   sdio_in,
  output logic                        sdio_out,
  output logic                        sdio_oe,
  output logic                        serial_data_out_pin,
  output logic                        serial_data_out_oe,
  input  wire logic                   port_abort_input,
  input  wire logic                   io_update,
  input  wire logic [3:0]             interface_select_pins,
  input  wire dds_port_pkg::par_bus_s par_in,
  output logic [15:0]                 pdata_out,
  output logic                        pdata_oe,
  output logic                        serial_mode,
  output logic                        parallel_mode
);
  import dds_port_pkg::*;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  sel_ff1;
    logic [3:0]  sel_ff2;
    par_bus_s    par_ff1;
    par_bus_s    par_ff2;
    par_bus_s    par_ff3;
    logic        upd_ff1;
    logic        upd_ff2;
    logic        upd_ff3;
    logic        tog_ff1;
    logic        tog_ff2;
    logic        tog_ff3;
    logic [5:0]  addr_ff1;
    logic [5:0]  addr_ff2;
    logic        par_mode;
    logic        ser_mode;
    logic [15:0] pdata;
    logic        pdata_oe;
  } sys_state_s;

  typedef struct packed {
    logic        ce_ff1;
    logic        ce_ff2;
    logic        ser_ff1;
    logic        ser_ff2;
    port_cfg_s   cfg_ff1;
    port_cfg_s   cfg_ff2;
    link_phase_e phase;
    logic [4:0]  cnt;
    logic [7:0]  sh;
    logic        rd;
    logic [5:0]  reg_addr;
  } link_state_s;

  // Byte hand-off kept apart so an abort cannot fake a toggle
  typedef struct packed {
    logic        wr_tog;
    logic [7:0]  wr_baddr;
    logic [7:0]  wr_byte;
  } hand_state_s;

  typedef struct packed {
    logic bit_out;
    logic sdio_oe;
    logic sdo_oe;
  } drive_state_s;

  sys_state_s   sys_reg;
  sys_state_s   sys_next;
  link_state_s  link_reg;
  link_state_s  link_next;
  hand_state_s  hand_reg;
  hand_state_s  hand_next;
  drive_state_s drv_reg;
  drive_state_s drv_next;

  buf_wr_s     buf_wr;
  logic        commit;
  logic [7:0]  rd_addr;
  logic [31:0] rd_word;
  logic [15:0] rd_pair;
  port_cfg_s   cfg;
  logic        link_rst_b;
  logic        drv_clr_b;
  logic        link_go;
  logic [7:0]  sh_new;
  logic        par_wr_edge;
  logic [4:0]  bit_pos;

  // ----------------------------------------
  // Buffer and active registers
  // ----------------------------------------
  reg_bank_mem u_bank (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .commit  (commit),
    .wr      (buf_wr),
    .rd_addr (rd_addr),
    .rd_word (rd_word),
    .rd_pair (rd_pair),
    .cfg     (cfg)
  );

  // ----------------------------------------
  // System clock side
  // ----------------------------------------
  assign commit      = sys_reg.upd_ff2 && !sys_reg.upd_ff3;
  // Data taken one stage late, since the host may drop it with the strobe
  assign par_wr_edge = sys_reg.par_mode && sys_reg.par_ff2.wr_n && !sys_reg.par_ff3.wr_n;
  // Serial address is stable from the instruction end, so two stages settle it
  assign rd_addr     = sys_reg.par_mode ? sys_reg.par_ff2.addr : {sys_reg.addr_ff2, 2'b00};

  always_comb begin
    buf_wr = '0;
    if (par_wr_edge) begin
      buf_wr.hi_en = 1'b1;
      buf_wr.addr  = sys_reg.par_ff3.addr;
      buf_wr.hi    = sys_reg.par_ff3.wide ? sys_reg.par_ff3.data[15:8] : sys_reg.par_ff3.data[7:0];
      buf_wr.lo_en = sys_reg.par_ff3.wide;
      buf_wr.lo    = sys_reg.par_ff3.data[7:0];
    end else if (sys_reg.ser_mode && (sys_reg.tog_ff2 != sys_reg.tog_ff3)) begin
      // Toggle arrives only after a whole byte; bundled data is held 8 bit times
      buf_wr.hi_en = 1'b1;
      buf_wr.addr  = hand_reg.wr_baddr;
      buf_wr.hi    = hand_reg.wr_byte;
    end
  end

  always_comb begin
    sys_next = sys_reg;
    if (ce) begin
      sys_next.sel_ff1  = interface_select_pins;
      sys_next.sel_ff2  = sys_reg.sel_ff1;
      sys_next.par_ff1  = par_in;
      sys_next.par_ff2  = sys_reg.par_ff1;
      sys_next.par_ff3  = sys_reg.par_ff2;
      sys_next.upd_ff1  = io_update;
      sys_next.upd_ff2  = sys_reg.upd_ff1;
      sys_next.upd_ff3  = sys_reg.upd_ff2;
      sys_next.tog_ff1  = hand_reg.wr_tog;
      sys_next.tog_ff2  = sys_reg.tog_ff1;
      sys_next.tog_ff3  = sys_reg.tog_ff2;
      sys_next.addr_ff1 = link_reg.reg_addr;
      sys_next.addr_ff2 = sys_reg.addr_ff1;
      sys_next.par_mode = (sys_reg.sel_ff2 == SEL_PARALLEL);
      sys_next.ser_mode = (sys_reg.sel_ff2 == SEL_SERIAL);
      sys_next.pdata_oe = sys_reg.par_mode && !sys_reg.par_ff2.rd_n;
      sys_next.pdata    = sys_reg.par_ff2.wide ? rd_pair : {8'h00, rd_pair[15:8]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_reg <= '{par_ff1: '1, par_ff2: '1, par_ff3: '1, default: '0};
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ----------------------------------------
  // Link side, rising serial clock
  // ----------------------------------------
  // Abort clears the link state only; the register bank never sees it
  assign link_rst_b = rst_b && !port_abort_input;
  assign link_go    = link_reg.ce_ff2 && link_reg.ser_ff2 && !cs_n;
  assign sh_new     = link_reg.cfg_ff2.lsb_first ? {sdio_in, link_reg.sh[7:1]}
                                                 : {link_reg.sh[6:0], sdio_in};

  always_comb begin
    link_next         = link_reg;
    hand_next         = hand_reg;
    link_next.ce_ff1  = ce;
    link_next.ce_ff2  = link_reg.ce_ff1;
    link_next.ser_ff1 = sys_reg.ser_mode;
    link_next.ser_ff2 = link_reg.ser_ff1;
    link_next.cfg_ff1 = cfg;
    link_next.cfg_ff2 = link_reg.cfg_ff1;
    if (link_go) begin
      link_next.sh = sh_new;
      case (link_reg.phase)
        PH_INSTR: begin
          if (link_reg.cnt == 5'(BYTE_LAST)) begin
            // No stall needed: the data phase starts on the very next edge
            link_next.phase    = PH_DATA;
            link_next.cnt      = '0;
            link_next.rd       = sh_new[INS_RW_BIT];
            link_next.reg_addr = sh_new[INS_ADDR_W-1:0];
          end else begin
            link_next.cnt = link_reg.cnt + 5'd1;
          end
        end
        PH_DATA: begin
          if (!link_reg.rd && (link_reg.cnt[2:0] == 3'(BYTE_LAST))) begin
            hand_next.wr_byte  = sh_new;
            // MSB-first starts at the top byte of the register
            hand_next.wr_baddr = {link_reg.reg_addr, link_reg.cfg_ff2.lsb_first ? link_reg.cnt[4:3]
                                                                                : ~link_reg.cnt[4:3]};
            hand_next.wr_tog   = !hand_reg.wr_tog;
          end
          if (link_reg.cnt == 5'(WORD_LAST)) begin
            link_next.phase = PH_INSTR;
            link_next.cnt   = '0;
          end else begin
            link_next.cnt = link_reg.cnt + 5'd1;
          end
        end
        default: begin
          link_next.phase = PH_INSTR;
          link_next.cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      link_reg <= '{phase: PH_INSTR, default: '0};
    end else begin
      link_reg <= link_next;
    end
  end

  // Only the full reset clears the hand-off; abort leaves registers alone
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      hand_reg <= '0;
    end else begin
      hand_reg <= hand_next;
    end
  end

  // ----------------------------------------
  // Link side, falling serial clock drive
  // ----------------------------------------
  // Chip select high clears the enables at once, without waiting for a clock
  assign drv_clr_b = link_rst_b && !cs_n;
  assign bit_pos   = link_reg.cfg_ff2.lsb_first ? link_reg.cnt : 5'(WORD_LAST) - link_reg.cnt;

  always_comb begin
    drv_next = drv_reg;
    if (link_reg.ce_ff2) begin
      drv_next.sdio_oe = 1'b0;
      drv_next.sdo_oe  = 1'b0;
      if (link_reg.ser_ff2 && (link_reg.phase == PH_DATA) && link_reg.rd) begin
        drv_next.bit_out = rd_word[bit_pos];
        drv_next.sdio_oe = !link_reg.cfg_ff2.sdio_in_only;
        drv_next.sdo_oe  = link_reg.cfg_ff2.sdio_in_only;
      end
    end
  end

  always_ff @(negedge sclk or negedge drv_clr_b) begin
    if (!drv_clr_b) begin
      drv_reg <= '0;
    end else begin
      drv_reg <= drv_next;
    end
  end

  assign sdio_out            = drv_reg.bit_out;
  assign sdio_oe             = drv_reg.sdio_oe;
  assign serial_data_out_pin = drv_reg.bit_out;
  assign serial_data_out_oe  = drv_reg.sdo_oe;
  assign pdata_out           = sys_reg.pdata;
  assign pdata_oe            = sys_reg.pdata_oe;
  assign serial_mode         = sys_reg.ser_mode;
  assign parallel_mode       = sys_reg.par_mode;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_par_select: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ce && sys_reg.sel_ff2 == 4'h0 |=> parallel_mode && !serial_mode)
    else $error("parallel mode not selected");

  a_ser_select: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ce && sys_reg.sel_ff2 == 4'h1 |=> serial_mode && !parallel_mode)
    else $error("serial mode not selected");

  a_wide_write: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    par_wr_edge && sys_reg.par_ff3.wide |-> buf_wr.lo_en && buf_wr.hi == sys_reg.par_ff3.data[15:8])
    else $error("16-bit write not split into two bytes");

  a_read_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ce ##1 pdata_oe |-> $past(sys_reg.par_ff2.rd_n) == 1'b0 && $past(sys_reg.par_mode))
    else $error("data bus driven without read strobe");

  a_instr_addr: assert property (
    @(posedge sclk) disable iff (!link_rst_b)
    link_go && link_reg.phase == PH_INSTR && link_reg.cnt == 5'd7
    |=> link_reg.phase == PH_DATA && link_reg.reg_addr == $past(sh_new[5:0]) && link_reg.rd == $past(sh_new[7]))
    else $error("instruction byte not decoded after eight bits");

  a_suspend_hold: assert property (
    @(posedge sclk) disable iff (!link_rst_b)
    cs_n |=> link_reg.cnt == $past(link_reg.cnt) && link_reg.phase == $past(link_reg.phase))
    else $error("cycle advanced while deselected");

  a_byte_commit: assert property (
    @(posedge sclk) disable iff (!link_rst_b)
    link_go && link_reg.phase == PH_DATA && !link_reg.rd && link_reg.cnt[2:0] != 3'd7
    |=> hand_reg.wr_tog == $past(hand_reg.wr_tog))
    else $error("partial byte handed to the buffer");

  a_sdo_quiet: assert property (
    @(negedge sclk) disable iff (!drv_clr_b)
    !link_reg.cfg_ff2.sdio_in_only ##1 !link_reg.cfg_ff2.sdio_in_only |-> !serial_data_out_oe)
    else $error("separate output driven in 2-wire mode");

endmodule

// *** hdl/reg_bank_mem.sv ***
/*
  Port buffer and active register bank with registered read ports.
  Assumes all inputs are on clk_sys; commit is a one-cycle pulse.
*/
`timescale 1ns/1ps
module reg_bank_mem (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   commit,
  input  wire dds_port_pkg::buf_wr_s  wr,
  input  wire logic [7:0]             rd_addr,
  output logic [31:0]                 rd_word,
  output logic [15:0]                 rd_pair,
  output dds_port_pkg::port_cfg_s     cfg
);
  import dds_port_pkg::*;

  typedef struct packed {
    bank_t       buffer;
    bank_t       active;
    logic [31:0] rd_word;
    logic [15:0] rd_pair;
    port_cfg_s   cfg;
  } mem_state_s;

  mem_state_s mem_reg;
  mem_state_s mem_next;
  logic [7:0] word_base;

  assign word_base = {rd_addr[7:2], 2'b00};

  always_comb begin
    mem_next = mem_reg;
    if (ce) begin
      if (wr.hi_en) begin
        mem_next.buffer[wr.addr] = wr.hi;
      end
      if (wr.lo_en) begin
        mem_next.buffer[wr.addr - 8'h01] = wr.lo;
      end
      // Serial reads and parallel readback see active data only
      if (commit) begin
        mem_next.active = mem_reg.buffer;
      end
      mem_next.rd_word = {mem_reg.active[word_base | 8'h03], mem_reg.active[word_base | 8'h02],
                          mem_reg.active[word_base | 8'h01], mem_reg.active[word_base]};
      mem_next.rd_pair = {mem_reg.active[rd_addr], mem_reg.active[rd_addr - 8'h01]};
      mem_next.cfg.lsb_first    = mem_reg.active[CTL_BYTE_ADDR][CTL_LSB_FIRST_BIT];
      mem_next.cfg.sdio_in_only = mem_reg.active[CTL_BYTE_ADDR][CTL_SDIO_IN_ONLY_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg <= '{buffer: BANK_RESET, active: BANK_RESET, default: '0};
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rd_word = mem_reg.rd_word;
  assign rd_pair = mem_reg.rd_pair;
  assign cfg     = mem_reg.cfg;

  a_commit_copy: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ce && commit |=> mem_reg.active == $past(mem_reg.buffer))
    else $error("commit did not copy the buffer");

  a_low_byte_write: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ce && wr.lo_en && !wr.hi_en |=> mem_reg.buffer[$past(wr.addr) - 8'h01] == $past(wr.lo))
    else $error("lower byte not stored one address down");

endmodule

// *** inc/dds_port_pkg.sv ***
/*
  Shared constants and carrier types of the synthesizer host programming port.
  Assumes byte-wide register storage, 256 bytes, four bytes per serial register.
*/
package dds_port_pkg;

  // ----------------------------------------
  // Geometry and instruction layout
  // ----------------------------------------
  localparam int MEM_BYTES  = 256;
  localparam int WORD_LAST  = 31;
  localparam int BYTE_LAST  = 7;
  localparam int INS_RW_BIT = 7;
  localparam int INS_ADDR_W = 6;

  // ----------------------------------------
  // First control word, byte 0
  // ----------------------------------------
  localparam logic [7:0] CTL_BYTE_ADDR        = 8'h00;
  localparam int         CTL_LSB_FIRST_BIT    = 0;
  localparam int         CTL_SDIO_IN_ONLY_BIT = 1;
  localparam logic [7:0] CTL_BYTE_RESET       = 8'h08;

  // ----------------------------------------
  // Interface select codes
  // ----------------------------------------
  localparam logic [3:0] SEL_PARALLEL = 4'h0;
  localparam logic [3:0] SEL_SERIAL   = 4'h1;

  typedef logic [MEM_BYTES-1:0][7:0] bank_t;
  localparam bank_t BANK_RESET = bank_t'(CTL_BYTE_RESET);

  typedef enum logic {PH_INSTR, PH_DATA} link_phase_e;

  typedef struct packed {
    logic        wr_n;
    logic        rd_n;
    logic        wide;
    logic [7:0]  addr;
    logic [15:0] data;
  } par_bus_s;

  typedef struct packed {
    logic       hi_en;
    logic       lo_en;
    logic [7:0] addr;
    logic [7:0] hi;
    logic [7:0] lo;
  } buf_wr_s;

  typedef struct packed {
    logic lsb_first;
    logic sdio_in_only;
  } port_cfg_s;

endpackage

// *** verif/dds_host_programming_port_bench.sv ***
/*
  Self-checking bench of the host programming port: serial and parallel access,
  suspend, abort, commit, bit order and pin modes.
  Assumes spi_host_model stands at the serial pins; ce is held high.
*/
`timescale 1ns/1ps
module dds_host_programming_port_bench;
  import dds_port_pkg::*;
  logic        clk_sys;
  logic        rst_b;
  logic        port_abort_input;
  logic        io_update;
  logic [3:0]  sel;
  par_bus_s    par;
  par_bus_s    par_pin;
  wire         sclk, cs_n, sdio_in, sdio_out, sdio_oe, serial_data_out_pin, serial_data_out_oe;
  wire [15:0]  pdata_out;
  wire         pdata_oe, serial_mode, parallel_mode;
  logic [7:0]  buf_m [MEM_BYTES];
  logic [7:0]  act_m [MEM_BYTES];
  logic [31:0] r;
  int          n_errors, tests_run, cycles;

  // Data bus: device wins while it drives
  assign par_pin = pdata_oe ? par_bus_s'({par.wr_n, par.rd_n, par.wide, par.addr, pdata_out}) : par;

  dds_host_port dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe), .port_abort_input(port_abort_input), .io_update(io_update),
    .interface_select_pins(sel), .par_in(par_pin), .pdata_out(pdata_out), .pdata_oe(pdata_oe),
    .serial_mode(serial_mode), .parallel_mode(parallel_mode));

  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_data_out_pin(serial_data_out_pin), .serial_data_out_oe(serial_data_out_oe));

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] aword(input int a);
    return {act_m[4*a+3], act_m[4*a+2], act_m[4*a+1], act_m[4*a]};
  endfunction

  task automatic swr(input logic [5:0] a, input logic [31:0] d, input logic lsb, input logic three);
    host.frame({2'b01, a}, d, lsb, three, 40, 99, r);
    {buf_m[4*a+3], buf_m[4*a+2], buf_m[4*a+1], buf_m[4*a]} = d;
    @(posedge clk_sys);
  endtask

  task automatic srd(input logic [5:0] a, input logic lsb, input logic three, input int brk);
    host.frame({2'b10, a}, 32'h0, lsb, three, 40, brk, r);
    @(posedge clk_sys);
    chk(r, aword(a));
  endtask

  task automatic commit();
    @(posedge clk_sys) io_update <= 1'b1;
    repeat (3) @(posedge clk_sys);
    io_update <= 1'b0;
    repeat (4) @(posedge clk_sys);
    act_m = buf_m;
  endtask

  task automatic pw(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_sys) begin
      par.addr <= a;
      par.data <= d;
      par.wide <= w;
      par.wr_n <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    par.wr_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    buf_m[a] = w ? d[15:8] : d[7:0];
    if (w) buf_m[a-8'h01] = d[7:0];
  endtask

  task automatic pr(input logic [7:0] a);
    @(posedge clk_sys) begin
      par.addr <= a;
      par.rd_n <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) chk({pdata_oe, pdata_out}, {1'b1, 8'h00, act_m[a]});
    @(posedge clk_sys) par.rd_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) chk(pdata_oe, 1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes();
    logic [3:0] codes [4];
    codes = '{4'h0, 4'h1, 4'h2, 4'hf};
    foreach (codes[i]) begin
      @(posedge clk_sys) sel <= codes[i];
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys) chk({serial_mode, parallel_mode}, {codes[i] == 4'h1, codes[i] == 4'h0});
    end
    @(posedge clk_sys) sel <= SEL_SERIAL;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic t_serial();
    swr(6'd5, 32'hc3a5_5a3c, 1'b0, 1'b0);
    srd(6'd5, 1'b0, 1'b0, 99);
    chk({host.two_seen, host.three_seen}, 2'b10);
    commit();
    srd(6'd5, 1'b0, 1'b0, 99);
    srd(6'd4, 1'b0, 1'b0, 99);
  endtask

  task automatic t_suspend();
    host.frame(8'h49, 32'h7e81_0ff0, 1'b0, 1'b0, 40, 20, r);
    {buf_m[39], buf_m[38], buf_m[37], buf_m[36]} = 32'h7e81_0ff0;
    commit();
    // Suspend inside the instruction: the resumed read still returns register 9, and neither data pin drives while deselected
    srd(6'd9, 1'b0, 1'b0, 4);
    chk(host.float_bad, 1'b0);
  endtask

  task automatic t_abort();
    host.frame(8'h06, 32'h9e7f_ffff, 1'b0, 1'b0, 20, 99, r);
    buf_m[27] = 8'h9e;
    @(posedge clk_sys) port_abort_input <= 1'b1;
    repeat (3) @(posedge clk_sys);
    port_abort_input <= 1'b0;
    repeat (3) @(posedge clk_sys);
    swr(6'd7, 32'h1122_3344, 1'b0, 1'b0);
    commit();
    srd(6'd6, 1'b0, 1'b0, 99);
    srd(6'd5, 1'b0, 1'b0, 99);
    srd(6'd0, 1'b0, 1'b0, 99);
    srd(6'd7, 1'b0, 1'b0, 99);
  endtask

  task automatic t_lsb3();
    swr(6'd0, 32'h0000_000b, 1'b0, 1'b0);
    commit();
    swr(6'd8, 32'h8040_2011, 1'b1, 1'b1);
    commit();
    srd(6'd8, 1'b1, 1'b1, 99);
    chk({host.two_seen, host.three_seen}, 2'b01);
    srd(6'd0, 1'b1, 1'b1, 99);
  endtask

  task automatic t_par();
    @(posedge clk_sys) sel <= SEL_PARALLEL;
    repeat (6) @(posedge clk_sys);
    pw(8'h21, 16'ha55a, 1'b1);
    pw(8'h30, 16'hff3c, 1'b0);
    pr(8'h21);
    commit();
    pr(8'h21);
    pr(8'h20);
    pr(8'h30);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    port_abort_input = 1'b0;
    io_update = 1'b0;
    sel = SEL_SERIAL;
    par = '{1'b1, 1'b1, 1'b0, 8'h00, 16'h0000};
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    foreach (buf_m[i]) buf_m[i] = 8'h00;
    buf_m[0] = CTL_BYTE_RESET;
    act_m = buf_m;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_modes();
    t_serial();
    t_suspend();
    t_abort();
    t_lsb3();
    t_par();
    results();
  end
endmodule

// *** verif/spi_host_model.sv ***
/*
  Serial host in front of the programming port: makes sclk only inside frames,
  drives cs_n and the data pin, samples read bits on either data pin.
  Assumes the bench calls frame() from one process and resolves nothing else.
*/
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_data_out_pin,
  input  wire logic serial_data_out_oe
);
  logic drv;
  logic bit_q;
  logic two_seen;
  logic three_seen;
  logic float_bad;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
    bit_q = 1'b0;
    float_bad = 1'b0;
  end

  // Released wire shows the inverse of its last level, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_q : ~bit_q);

  // ----------------------------------------
  // Clock pulse with chip select high
  // ----------------------------------------
  task automatic idle_pulse();
    #80;
    if (sdio_oe !== 1'b0 || serial_data_out_oe !== 1'b0) float_bad = 1'b1;
    sclk = 1'b1;
    #80 sclk = 1'b0;
  endtask

  // ----------------------------------------
  // One framed cycle, optionally suspended at bit brk
  // ----------------------------------------
  task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input logic lsb,
                       input logic three, input int nbits, input int brk, output logic [31:0] rd);
    logic [39:0] tx;
    int          k;
    tx = {ins, wd};
    rd = 32'h0;
    two_seen = 1'b0;
    three_seen = 1'b0;
    #7;
    repeat (2) idle_pulse();
    cs_n = 1'b0;
    for (k = 0; k < nbits; k++) begin
      if (k == brk) begin
        cs_n = 1'b1;
        repeat (3) idle_pulse();
        cs_n = 1'b0;
      end
      drv = (k < 8) || !ins[7] || three;
      // Same bit order for instruction and data, clock never stalls
      bit_q = lsb ? (k < 8 ? tx[32+k] : tx[k-8]) : tx[39-k];
      #80;
      if (sdio_oe === 1'b1) two_seen = 1'b1;
      if (serial_data_out_oe === 1'b1) three_seen = 1'b1;
      if (k >= 8) rd[lsb ? k-8 : 39-k] = three ? serial_data_out_pin : sdio_in;
      sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    drv = 1'b0;
    #80;
  endtask
endmodule
